// >>> common/smsr_map.svh
`ifndef SMSR_MAP_SVH
`define SMSR_MAP_SVH

// frame layout
`define SMSR_FRAME_BITS     5'h10
`define SMSR_HDR_BITS       5'h08
`define SMSR_CNT_OVER       5'h11
`define SMSR_CMD_HI         15
`define SMSR_CMD_LO         14
`define SMSR_ADDR_HI        13
`define SMSR_ADDR_LO        9
`define SMSR_PARITY_BIT     8
`define SMSR_SUB_BIT        7
`define SMSR_DATA_HI        7
`define SMSR_DATA_LO        0
`define SMSR_TX_LOW_HI      14
`define SMSR_TX_LOW_LO      7
`define SMSR_HDR_ADDR_HI    5
`define SMSR_HDR_ADDR_LO    1

// commands
`define SMSR_CMD_READ       2'h0
`define SMSR_CMD_WRITE      2'h1

// register offsets
`define SMSR_ADDR_MONITOR   5'h00
`define SMSR_ADDR_SCRATCH0  5'h01

// monitor control fields
`define SMSR_MON_SEL_HI     7
`define SMSR_MON_SEL_LO     5
`define SMSR_MON_LOAD_BIT   4
`define SMSR_MON_ATT_BIT    3
`define SMSR_MON_WMASK      8'hF8
`define SMSR_MON_RESET      8'h00
`define SMSR_SCRATCH_RESET  8'h00
`define SMSR_BYTE_ZERO      8'h00

`endif

// >>> common/smsr_pkg.sv
package smsr_pkg;

    typedef enum logic [2:0] {
        SMSR_SRC_OFF    = 3'b000,
        SMSR_SRC_ICOPY  = 3'b001,
        SMSR_SRC_VREF   = 3'b010,
        SMSR_SRC_TEMP   = 3'b011,
        SMSR_SRC_IN0    = 3'b100,
        SMSR_SRC_IN1    = 3'b101,
        SMSR_SRC_SUPPLY = 3'b110,
        SMSR_SRC_SENSE  = 3'b111
    } smsr_source_t;

    // serial pins seen by the device
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } smsr_spi_in_t;

    // decoded analog monitor controls
    typedef struct packed {
        smsr_source_t source_sel;
        logic         internal_load_resistor_en;
        logic         input_attenuate_en;
        logic         input_gain_en;
    } smsr_monitor_ctl_t;

    typedef struct packed {
        logic        sclk_q;
        logic        cs_n_q;
        logic [4:0]  cnt;
        logic [15:0] rx;
        logic [15:0] tx;
        logic        hdr_pend;
        logic        done;
    } smsr_shift_state_t;

endpackage

// >>> src/smsr_spi_shift.sv
`timescale 1ns/1ps
`default_nettype none
`include "smsr_map.svh"

module smsr_spi_shift (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // serial pins
    input  wire smsr_pkg::smsr_spi_in_t spi,
    output logic                       miso,
    output logic                       miso_oe,
    // response bytes
    input  wire logic [7:0]            status_byte,
    input  wire logic [7:0]            resp_low,
    // received frame
    output logic [7:0]                 hdr,
    output logic                       hdr_ready,
    output logic [15:0]                frame,
    output logic                       frame_done
);

    smsr_pkg::smsr_shift_state_t st;
    smsr_pkg::smsr_shift_state_t next_st;

    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;

    always_comb begin
        sclk_rise = spi.sclk & ~st.sclk_q & ~spi.cs_n;
        sclk_fall = ~spi.sclk & st.sclk_q & ~spi.cs_n;
        cs_fall   = ~spi.cs_n & st.cs_n_q;
        cs_rise   = spi.cs_n & ~st.cs_n_q;
        next_st          = st;
        next_st.sclk_q   = spi.sclk;
        next_st.cs_n_q   = spi.cs_n;
        next_st.done     = 1'b0;
        next_st.hdr_pend = 1'b0;
        if (cs_fall) begin
            next_st.cnt = 5'h00;
            next_st.tx  = {status_byte, `SMSR_BYTE_ZERO};
        end else if (sclk_rise) begin
            next_st.rx = {st.rx[14:0], spi.mosi};
            if (st.cnt != `SMSR_CNT_OVER) begin
                next_st.cnt = st.cnt + 5'h01;
            end
            if (st.cnt == `SMSR_HDR_BITS - 5'h01) begin
                next_st.hdr_pend = 1'b1;
            end
        end else if (sclk_fall) begin
            next_st.tx = {st.tx[14:0], 1'b0};
        end
        // low byte loaded before the next falling edge; seven shifts are
        // already done, so it sits just below the last status bit
        if (st.hdr_pend) begin
            next_st.tx[`SMSR_TX_LOW_HI:`SMSR_TX_LOW_LO] = resp_low;
        end
        if (cs_rise && st.cnt == `SMSR_FRAME_BITS) begin
            next_st.done = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st        <= '0;
            st.sclk_q <= 1'b0;
            st.cs_n_q <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign miso       = st.tx[15];
    assign miso_oe    = ~st.cs_n_q;
    assign hdr        = st.rx[7:0];
    assign hdr_ready  = st.hdr_pend;
    assign frame      = st.rx;
    assign frame_done = st.done;

endmodule

`default_nettype wire

// >>> src/smsr_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "smsr_map.svh"

module smsr_bank #(
    parameter int NUM_SCRATCH = 4
) (
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst,
    // serial pins
    input  wire logic                        sclk,
    input  wire logic                        cs_n,
    input  wire logic                        mosi,
    output logic                             miso,
    output logic                             miso_oe,
    // device context
    input  wire logic [7:0]                  fixed_status,
    input  wire logic                        parity_en,
    input  wire logic                        can_reg_on,
    input  wire logic                        normal_mode,
    // monitor controls
    output smsr_pkg::smsr_monitor_ctl_t      monitor_ctl,
    // frame outcome
    output logic                             write_applied,
    output logic                             frame_error
);

    // refuse scratch counts that the five-bit address cannot reach
    generate
        if (NUM_SCRATCH < 1 || NUM_SCRATCH > 31) begin : g_bad_count
            $error("NUM_SCRATCH must be 1 to 31");
        end
    endgenerate

    typedef struct packed {
        logic [7:0]                   analog_monitor_control;
        logic [NUM_SCRATCH-1:0][7:0]  scratch;
        logic                         applied;
        logic                         err;
    } smsr_bank_state_t;

    smsr_bank_state_t st;
    smsr_bank_state_t next_st;

    smsr_pkg::smsr_spi_in_t spi;
    logic [7:0]  hdr;
    logic        hdr_ready;
    logic [15:0] frame;
    logic        frame_done;
    logic [7:0]  resp_low;
    logic [1:0]  cmd;
    logic [4:0]  addr;
    logic [4:0]  hdr_addr;
    logic        parity_calc;
    logic        parity_ok;
    logic        is_write;
    logic        mon_hit;
    logic        mon_keep;
    logic [NUM_SCRATCH-1:0]      scr_wr;
    logic [NUM_SCRATCH-1:0][7:0] scr_rd;
    logic                        mon_wr;
    logic                        input_src;
    smsr_pkg::smsr_source_t      mon_sel;

    assign spi = '{sclk: sclk, cs_n: cs_n, mosi: mosi};

    smsr_spi_shift u_shift (
        .mclk        (mclk),
        .rst         (rst),
        .spi         (spi),
        .miso        (miso),
        .miso_oe     (miso_oe),
        .status_byte (fixed_status),
        .resp_low    (resp_low),
        .hdr         (hdr),
        .hdr_ready   (hdr_ready),
        .frame       (frame),
        .frame_done  (frame_done)
    );

    assign cmd      = frame[`SMSR_CMD_HI:`SMSR_CMD_LO];
    assign addr     = frame[`SMSR_ADDR_HI:`SMSR_ADDR_LO];
    assign hdr_addr = hdr[`SMSR_HDR_ADDR_HI:`SMSR_HDR_ADDR_LO];
    // odd parity over all but bit 8
    assign parity_calc = ~(^{frame[`SMSR_CMD_HI:`SMSR_ADDR_LO], frame[`SMSR_DATA_HI:`SMSR_DATA_LO]});
    // check only when enabled; otherwise bit 8 ignored
    assign parity_ok = ~parity_en | (frame[`SMSR_PARITY_BIT] == parity_calc);
    assign is_write  = frame_done & (cmd == `SMSR_CMD_WRITE);
    assign mon_hit   = frame_done & (addr == `SMSR_ADDR_MONITOR);
    // monitor held only with regulator on in Normal
    assign mon_keep  = can_reg_on & normal_mode;
    // monitor write needs good parity, regulator on, Normal
    assign mon_wr    = is_write & parity_ok & mon_keep & mon_hit;

    // per-entry write strobe and read data
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SCRATCH; gi++) begin : g_scr
            assign scr_wr[gi] = is_write & parity_ok
                                & (addr == `SMSR_ADDR_SCRATCH0 + 5'(gi));
            assign scr_rd[gi] = (hdr_addr == `SMSR_ADDR_SCRATCH0 + 5'(gi))
                                ? st.scratch[gi] : `SMSR_BYTE_ZERO;
        end
    endgenerate

    // low response byte from the addressed register
    always_comb begin
        resp_low = `SMSR_BYTE_ZERO;
        // only taken while the header is fresh
        if (hdr_ready) begin
            if (hdr_addr == `SMSR_ADDR_MONITOR) begin
                // reads as cleared while regulator off
                resp_low = can_reg_on ? st.analog_monitor_control : `SMSR_MON_RESET;
            end
            for (int i = 0; i < NUM_SCRATCH; i++) begin
                resp_low = resp_low | scr_rd[i];
            end
        end
    end

    always_comb begin
        next_st         = st;
        next_st.applied = 1'b0;
        // bad parity write flagged, not applied
        next_st.err     = is_write & ~parity_ok;
        for (int i = 0; i < NUM_SCRATCH; i++) begin
            if (scr_wr[i]) begin
                next_st.scratch[i] = frame[7:0];
            end
        end
        if (mon_wr) begin
            // control bits stored, low bits read zero
            next_st.analog_monitor_control = frame[7:0] & `SMSR_MON_WMASK;
        end
        next_st.applied = (|scr_wr) | mon_wr;
        if (!mon_keep) begin
            next_st.analog_monitor_control = `SMSR_MON_RESET;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st.analog_monitor_control <= `SMSR_MON_RESET;
            for (int i = 0; i < NUM_SCRATCH; i++) begin
                st.scratch[i] <= `SMSR_SCRATCH_RESET;
            end
            st.applied <= 1'b0;
            st.err     <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign mon_sel   = smsr_pkg::smsr_source_t'(
        st.analog_monitor_control[`SMSR_MON_SEL_HI:`SMSR_MON_SEL_LO]);
    // gain or attenuation on inputs only
    assign input_src = (mon_sel == smsr_pkg::SMSR_SRC_IN0) | (mon_sel == smsr_pkg::SMSR_SRC_IN1);

    // one process drives the whole control struct
    always_comb begin
        monitor_ctl.source_sel                = mon_sel;
        monitor_ctl.internal_load_resistor_en = st.analog_monitor_control[`SMSR_MON_LOAD_BIT];
        monitor_ctl.input_attenuate_en        = input_src & st.analog_monitor_control[`SMSR_MON_ATT_BIT];
        monitor_ctl.input_gain_en             = input_src & ~st.analog_monitor_control[`SMSR_MON_ATT_BIT];
    end

    assign write_applied = st.applied;
    assign frame_error   = st.err;

endmodule

`default_nettype wire

// >>> tb/smsr_bank_chk.sv
`timescale 1ns/1ps
`default_nettype none
module smsr_bank_chk (
    // clock and reset
    input wire logic                   mclk,
    input wire logic                   rst,
    // serial pins
    input wire logic                   sclk,
    input wire logic                   cs_n,
    input wire logic                   miso,
    input wire logic                   miso_oe,
    // context and outcome
    input wire logic                   parity_en,
    input wire logic                   can_reg_on,
    input wire logic                   normal_mode,
    input wire smsr_pkg::smsr_monitor_ctl_t monitor_ctl,
    input wire logic                   write_applied,
    input wire logic                   frame_error
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_pulse_single: assert property ((write_applied || frame_error) |=> !(write_applied || frame_error))
        else $error("outcome pulse longer than one cycle");
    a_pulse_excl: assert property (!(write_applied && frame_error))
        else $error("applied and refused together");
    a_pulse_timing: assert property ($rose(write_applied || frame_error) |-> $past(cs_n, 2) && !$past(cs_n, 3))
        else $error("outcome not two cycles after select release");
    a_err_parity: assert property (frame_error |-> parity_en)
        else $error("refusal with parity check off");
    a_oe_select: assert property (miso_oe == !$past(cs_n))
        else $error("output enable does not follow select");
    a_mon_clear: assert property ((!$past(can_reg_on) || !$past(normal_mode)) |-> monitor_ctl == 6'h00)
        else $error("monitor not cleared");
    a_gain_decode: assert property (!(monitor_ctl.input_attenuate_en && monitor_ctl.input_gain_en) &&
        ((monitor_ctl.input_attenuate_en || monitor_ctl.input_gain_en) == (monitor_ctl.source_sel[2:1] == 2'h2)))
        else $error("gain or attenuation outside inputs");
    a_miso_stable: assert property ($rose(sclk) && !cs_n |-> $stable(miso))
        else $error("serial output moved at clock rise");
endmodule
bind smsr_bank smsr_bank_chk chk (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .miso(miso),
    .miso_oe(miso_oe), .parity_en(parity_en), .can_reg_on(can_reg_on), .normal_mode(normal_mode),
    .monitor_ctl(monitor_ctl), .write_applied(write_applied), .frame_error(frame_error));
`default_nettype wire

// >>> tb/smsr_host.sv
`timescale 1ns/1ps
`default_nettype none
module smsr_host (
    // clock
    input wire logic    mclk,
    // serial pins
    output logic        sclk,
    output logic        cs_n,
    output logic        mosi,
    input wire logic    miso,
    // returned word
    output logic [15:0] rx_word,
    output logic        rx_valid
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        rx_word = 16'h0000;
        rx_valid = 1'b0;
    end
    task automatic gap(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic xfer(input logic [15:0] w, input int n);
        cs_n = 1'b0;
        gap(3);
        for (int i = 15; i > 15 - n; i--) begin
            mosi = w[i];
            gap(3);
            sclk = 1'b1;
            rx_word[i] = miso;
            gap(3);
            sclk = 1'b0;
        end
        gap(3);
        cs_n = 1'b1;
        // released line shows the inverse
        mosi = ~mosi;
        rx_valid = (n == 16);
        gap(1);
        rx_valid = 1'b0;
        gap(2);
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_smsr_bank.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin n_mismatch++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_smsr_bank;
    logic        mclk = 1'b0, rst = 1'b1, parity_en = 1'b0, can_reg_on = 1'b1, normal_mode = 1'b1;
    logic [7:0]  fixed_status = 8'h00;
    logic        sclk, cs_n, mosi, miso, miso_oe, write_applied, frame_error, rx_valid, io;
    logic [15:0] rx_word, got_rd;
    logic [7:0]  d;
    logic [1:0]  got_ev;
    logic [7:0]  mem [0:4];
    logic [15:0] exp_rd [$];
    logic [1:0]  exp_ev [$];
    int          n_mismatch = 0, check_count = 0, cycles = 0;
    smsr_pkg::smsr_monitor_ctl_t monitor_ctl;
    always #50 mclk = ~mclk;
    smsr_bank #(.NUM_SCRATCH(4)) dut (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .fixed_status(fixed_status), .parity_en(parity_en),
        .can_reg_on(can_reg_on), .normal_mode(normal_mode), .monitor_ctl(monitor_ctl),
        .write_applied(write_applied), .frame_error(frame_error));
    smsr_host host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
        .rx_word(rx_word), .rx_valid(rx_valid));
    task automatic end_sim();
        if (exp_rd.size() + exp_ev.size() != 0) n_mismatch++;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_sim();
        end
        if (rx_valid) begin
            got_rd = exp_rd.size() ? exp_rd.pop_front() : 16'hXXXX;
            `CHK("read word", got_rd, rx_word)
        end
    end
    always @(negedge mclk) if (write_applied || frame_error) begin
        got_ev = exp_ev.size() ? exp_ev.pop_front() : 2'hX;
        `CHK("outcome", got_ev, {write_applied, frame_error})
    end
    // one frame; notes the read word and the write outcome
    task automatic frm(input logic [1:0] cmd, input logic [4:0] a, input logic [7:0] v, input int n = 16,
        input logic bad = 1'b0);
        logic [15:0] w;
        logic        ok;
        logic        keep;
        w = {cmd, a, 1'b0, v};
        w[8] = parity_en & (~^{w[15:9], w[7:0]} ^ bad);
        ok = !(parity_en && bad);
        // monitor writes land only with regulator on in Normal
        keep = ok && (a == 5'h00 ? can_reg_on && normal_mode : a <= 5'h04);
        fixed_status = 8'($urandom);
        if (n == 16) begin
            exp_rd.push_back({fixed_status, a <= 5'h04 ? mem[a] : 8'h00});
            if (cmd == 2'h1 && (keep || !ok)) exp_ev.push_back({keep, !ok});
            if (cmd == 2'h1 && keep) mem[a] = a != 5'h00 ? v : v & 8'hF8;
        end
        host.xfer(w, n);
    endtask
    initial begin
        void'($urandom(32'hEEDB134C));
        for (int i = 0; i < 5; i++) mem[i] = 8'h00;
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        for (int a = 0; a < 7; a++) frm(2'h0, 5'(a), 8'h00);
        for (int a = 1; a < 5; a++) frm(2'h1, 5'(a), 8'($urandom));
        for (int a = 1; a < 5; a++) frm(2'h0, 5'(a), 8'h00);
        parity_en = 1'b1;
        frm(2'h1, 5'h03, 8'h69);
        frm(2'h1, 5'h03, 8'h40, 16, 1'b1);
        frm(2'h1, 5'h02, 8'h40);
        frm(2'h1, 5'h01, 8'hFF, 16, 1'b1);
        parity_en = 1'b0;
        frm(2'h1, 5'h01, 8'h5A, 15);
        frm(2'h2, 5'h01, 8'h5A);
        frm(2'h3, 5'h02, 8'h5A);
        for (int a = 1; a < 4; a++) frm(2'h0, 5'(a), 8'h00);
        for (int s = 0; s < 16; s++) begin
            d = {3'(s >> 1), 1'($urandom), 1'(s), 3'($urandom)};
            frm(2'h1, 5'h00, d);
            io = d[7:6] == 2'h2;
            `CHK("monitor", {d[7:4], d[3] & io, !d[3] & io}, monitor_ctl)
            frm(2'h0, 5'h00, 8'h00);
        end
        for (int k = 0; k < 2; k++) begin
            frm(2'h1, 5'h00, 8'hB8);
            @(negedge mclk);
            {can_reg_on, normal_mode} = k ? 2'h1 : 2'h2;
            mem[0] = 8'h00;
            repeat (2) @(negedge mclk);
            `CHK("monitor cleared", 6'h00, monitor_ctl)
            frm(2'h1, 5'h00, 8'hE0);
            `CHK("monitor write ignored", 6'h00, monitor_ctl)
            frm(2'h0, 5'h00, 8'h00);
            {can_reg_on, normal_mode} = 2'h3;
            frm(2'h0, 5'h00, 8'h00);
        end
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        for (int i = 0; i < 5; i++) mem[i] = 8'h00;
        for (int a = 1; a < 5; a++) frm(2'h0, 5'(a), 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire
